//--- rtl/adc_ctl_regs.svh
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// Register byte addresses.
`define ADC_OFF_CONTROL     12'h000
`define ADC_OFF_RESULT_HIGH 12'h004
`define ADC_OFF_RESULT_LOW  12'h008
// Control fields.
`define ADC_BIT_BUSY  0
`define ADC_BIT_DIV   1
`define ADC_BIT_ROUTE 2
`define ADC_BIT_DIFF  3
`define ADC_CHAN_LSB  4
`define ADC_CONTROL_RESET 8'h00
// Timing: sample and result lengths in converter clock ticks, slow divider in system clock cycles.
`define ADC_SAMPLE_TICKS 4'h3
`define ADC_RESULT_BITS  4'hA
`define ADC_SLOW_DIV     5'h10
// Channel codes.
`define ADC_CH_TEMP      4'h7
`define ADC_CH_ROUTE_OUT 4'hE
`define ADC_CH_CONV_IN   4'hF
`endif

//--- rtl/adc_ctl_pkg.sv
package adc_ctl_pkg;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONV   = 4'b0100,
		ST_DONE   = 4'b1000
	} conv_state_e;
endpackage

//--- rtl/adc_clk_prescaler.sv
`include "adc_ctl_regs.svh"
module adc_clk_prescaler (
	// Clock and reset.
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// Control.
	input  wire logic run,
	input  wire logic divSel,
	// Converter tick.
	output logic      convTick
);
	logic [4:0] divCount;

	// Counter is held cleared while idle so the converter clock is truly stopped.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !run) begin
			divCount <= 5'h0_0;
		end else if (divCount == `ADC_SLOW_DIV - 5'h0_1) begin
			divCount <= 5'h0_0;
		end else begin
			divCount <= divCount + 5'h0_1;
		end
	end

	// Divide by one ticks every cycle; divide by sixteen once per wrap.
	assign convTick = run && (!divSel || divCount == `ADC_SLOW_DIV - 5'h0_1);
endmodule

//--- rtl/adc_conversion_control.sv
// Register access over AHB-Lite and the address map were left to the implementer.
`include "adc_ctl_regs.svh"
module adc_conversion_control (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Analog front end controls.
	output logic      [15:0] chanEnable,
	output logic             routeOutEnable,
	output logic             convInputEnable,
	output logic             convInputFromPin,
	output logic             diffMode,
	output logic             convClockOn,
	output logic             sampleHold,
	output logic             trialBit,
	input  wire logic        compareHigh,
	input  wire logic        ampEnabled
);
	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic        wrPending;
	logic        rdPending;
	logic [11:0] addrHold;
	logic [7:0]  conv_control_reg;
	logic [7:0]  result_high_byte;
	logic [1:0]  result_low_bits;
	logic [9:0]  sarValue;
	logic [3:0]  stepCount;
	logic        convDone;
	logic        convTick;
	adc_ctl_pkg::conv_state_e state;

	wire addrTaken = hsel && hready && htrans[1];

	// Zero-wait slave: every transfer completes in its first data-phase cycle.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wrPending <= 1'b0;
			rdPending <= 1'b0;
			addrHold  <= 12'h000;
		end else begin
			wrPending <= addrTaken && hwrite;
			rdPending <= addrTaken && !hwrite;
			if (addrTaken) begin
				addrHold <= haddr;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	wire ctlWrite  = wrPending && addrHold == `ADC_OFF_CONTROL;
	wire highWrite = wrPending && addrHold == `ADC_OFF_RESULT_HIGH;
	wire lowWrite  = wrPending && addrHold == `ADC_OFF_RESULT_LOW;

	// Read mux is registered off the address phase; unmapped reads return zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (addrTaken && !hwrite) begin
			case (haddr)
				`ADC_OFF_CONTROL:     hrdata <= {24'h00_0000, next_control()};
				`ADC_OFF_RESULT_HIGH: hrdata <= {24'h00_0000, result_high_byte};
				`ADC_OFF_RESULT_LOW:  hrdata <= {24'h00_0000, result_low_bits, 6'h00};
				default:              hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Current control view including a completion landing this cycle.
	function automatic logic [7:0] next_control();
		next_control = conv_control_reg;
		if (convDone) begin
			next_control[`ADC_BIT_BUSY] = 1'b0;
		end
	endfunction

	// ****************************************
	// Control register
	// ****************************************
	wire busy    = conv_control_reg[`ADC_BIT_BUSY];
	wire route   = conv_control_reg[`ADC_BIT_ROUTE];
	wire [3:0] channel = conv_control_reg[`ADC_CHAN_LSB +: 4];

	// Software write wins over completion so a zero-then-one restart is never lost.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			conv_control_reg <= `ADC_CONTROL_RESET;
		end else if (ctlWrite) begin
			conv_control_reg <= hwdata[7:0];
		end else if (convDone) begin
			conv_control_reg[`ADC_BIT_BUSY] <= 1'b0;
		end
	end

	// A write with busy low, or any control write, restarts the sequencer.
	wire abort = ctlWrite;

	// ****************************************
	// Converter clock and sequencer
	// ****************************************
	adc_clk_prescaler u_prescaler (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.run      (busy && !abort),
		.divSel   (conv_control_reg[`ADC_BIT_DIV]),
		.convTick (convTick)
	);

	assign convClockOn = busy;
	assign diffMode    = conv_control_reg[`ADC_BIT_DIFF];

	// Sample for three ticks, then ten trial bits MSB first.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state     <= adc_ctl_pkg::ST_IDLE;
			stepCount <= 4'h0;
			sarValue  <= 10'h000;
		end else if (abort || !busy) begin
			state     <= adc_ctl_pkg::ST_IDLE;
			stepCount <= 4'h0;
			sarValue  <= 10'h000;
		end else if (convTick) begin
			case (state)
				adc_ctl_pkg::ST_IDLE: begin
					state     <= adc_ctl_pkg::ST_SAMPLE;
					stepCount <= 4'h1;
				end
				adc_ctl_pkg::ST_SAMPLE: begin
					if (stepCount == `ADC_SAMPLE_TICKS) begin
						state     <= adc_ctl_pkg::ST_CONV;
						stepCount <= 4'h0;
						sarValue  <= 10'h200;
					end else begin
						stepCount <= stepCount + 4'h1;
					end
				end
				adc_ctl_pkg::ST_CONV: begin
					if (!compareHigh) begin
						sarValue[4'h9 - stepCount] <= 1'b0;
					end
					if (stepCount == `ADC_RESULT_BITS - 4'h1) begin
						state <= adc_ctl_pkg::ST_DONE;
					end else begin
						sarValue[4'h8 - stepCount] <= 1'b1;
						stepCount <= stepCount + 4'h1;
					end
				end
				adc_ctl_pkg::ST_DONE: begin
					state <= adc_ctl_pkg::ST_IDLE;
				end
				default: begin
					state <= adc_ctl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign convDone   = state == adc_ctl_pkg::ST_DONE && busy && !abort;
	assign sampleHold = state == adc_ctl_pkg::ST_SAMPLE;
	assign trialBit   = state == adc_ctl_pkg::ST_CONV;

	// ****************************************
	// Result registers
	// ****************************************
	// No reset: contents are undefined until written by software or a conversion.
	always_ff @(posedge sys_clk) begin
		if (convDone) begin
			result_high_byte <= sarValue[9:2];
			result_low_bits  <= sarValue[1:0];
		end else begin
			if (highWrite) begin
				result_high_byte <= hwdata[7:0];
			end
			if (lowWrite) begin
				result_low_bits <= hwdata[7:6];
			end
		end
	end

	// ****************************************
	// Analog path gating
	// ****************************************
	// Routing holds the path open while idle, since external delay exceeds the sample window.
	wire pathOpen = busy || route || ampEnabled;

	always_comb begin
		chanEnable = 16'h0000;
		if (pathOpen && !(route && channel == `ADC_CH_TEMP)) begin
			chanEnable[channel] = 1'b1;
		end
	end

	assign routeOutEnable   = route;
	assign convInputFromPin = route;
	assign convInputEnable  = pathOpen;
endmodule

//--- verif/adc_conversion_control_assertions.sv
module adc_conversion_control_assertions (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// Watched ports.
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [15:0] chanEnable,
	input wire logic        routeOutEnable,
	input wire logic        convInputEnable,
	input wire logic        convInputFromPin,
	input wire logic        convClockOn,
	input wire logic        sampleHold,
	input wire logic        trialBit,
	input wire logic        ampEnabled
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// A start allows up to 20 cycles for the first slow tick to arrive.
	sequence s_start; $rose(convClockOn); endsequence
	sequence s_sample; ##[0:20] (sampleHold || !convClockOn); endsequence
	property p_bus; hreadyout && !hresp; endproperty
	property p_route; routeOutEnable |-> convInputFromPin && convInputEnable; endproperty
	property p_gate; !convClockOn && !routeOutEnable && !ampEnabled |-> chanEnable == 16'h0000; endproperty
	property p_clkoff; !convClockOn |-> !sampleHold && !trialBit; endproperty
	property p_onehot; $onehot0(chanEnable); endproperty
	property p_phase; sampleHold |-> !trialBit; endproperty
	property p_start; s_start |-> s_sample; endproperty
	property p_sar; $fell(sampleHold) && convClockOn |-> trialBit; endproperty
	property p_done; $fell(trialBit) && $past(convClockOn) |-> ##[0:17] !convClockOn; endproperty
	a_bus: assert property (p_bus) else $error("bus answer not ready or not okay");
	a_route: assert property (p_route) else $error("routing without pin input path");
	a_gate: assert property (p_gate) else $error("channel enabled while idle");
	a_clkoff: assert property (p_clkoff) else $error("sequencer active with clock off");
	a_onehot: assert property (p_onehot) else $error("more than one channel enabled");
	a_phase: assert property (p_phase) else $error("sample and trial overlap");
	a_start: assert property (p_start) else $error("no sample phase after start");
	a_sar: assert property (p_sar) else $error("sample not followed by trial");
	a_done: assert property (p_done) else $error("clock stays on after last trial");
endmodule
bind adc_conversion_control adc_conversion_control_assertions chk (.sys_clk, .sys_rst, .hreadyout, .hresp,
	.chanEnable, .routeOutEnable, .convInputEnable, .convInputFromPin, .convClockOn, .sampleHold, .trialBit,
	.ampEnabled);

//--- verif/adc_conversion_control_bench.sv
module adc_conversion_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus, bus tasks and checks
	// ****************************************
	logic        sys_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, compareHigh, ampEnabled;
	logic        routeOutEnable, convInputEnable, convInputFromPin, diffMode, convClockOn, sampleHold, trialBit;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [15:0] chanEnable;
	int          err_total, compares, cyc;
	// The single slave's ready is the bus ready.
	assign hready = hreadyout;
	adc_conversion_control DUT (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .chanEnable, .routeOutEnable, .convInputEnable, .convInputFromPin,
		.diffMode, .convClockOn, .sampleHold, .trialBit, .compareHigh, .ampEnabled);
	task automatic print_verdict();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Address phase held until ready, then data phase held until ready again.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
		xfer(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	// Pins are sampled after the launching edge's updates land.
	task automatic pins(input logic [20:0] e);
		#1;
		chk("pins", {11'h000, e}, {11'h000, chanEnable, routeOutEnable, convInputFromPin, convInputEnable,
			diffMode, convClockOn});
	endtask
	task automatic conv(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input int lo, input int hi);
		int n;
		n = 0;
		xfer(1'b1, 12'h000, {24'h00_0000, c});
		#1;
		chk("clock on", 32'h0000_0001, {31'h0, convClockOn});
		while (convClockOn === 1'b1 && n < 400) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("duration", 32'h0000_0001, {31'h0, n >= lo && n <= hi});
		rdchk(12'h000, {24'h00_0000, c & 8'hFE}, "control");
		rdchk(12'h004, {24'h00_0000, h}, "high");
		rdchk(12'h008, {24'h00_0000, l}, "low");
	endtask
	// A hang counts as a mismatch and closes the run.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		{sys_rst, hsel, hwrite, compareHigh, ampEnabled} = 5'b10000;
		{haddr, htrans, hwdata, cyc, err_total, compares} = '0;
		hsize = 3'b010;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdchk(12'h000, 32'h0000_0000, "control");
		pins(21'h00_0000);
		xfer(1'b1, 12'h000, 32'h0000_00A8);
		pins({16'h0000, 5'b00010});
		rdchk(12'h000, 32'h0000_00A8, "control");
		ampEnabled <= 1'b1;
		@(posedge sys_clk);
		pins({16'h0400, 5'b00110});
		ampEnabled <= 1'b0;
		xfer(1'b1, 12'h000, 32'h0000_00C4);
		pins({16'h1000, 5'b11100});
		xfer(1'b1, 12'h000, 32'h0000_0074);
		pins({16'h0000, 5'b11100});
		rdchk(12'h010, 32'h0000_0000, "unmapped");
		xfer(1'b1, 12'h004, 32'h0000_005A);
		xfer(1'b1, 12'h008, 32'h0000_00FF);
		rdchk(12'h004, 32'h0000_005A, "high");
		rdchk(12'h008, 32'h0000_00C0, "low");
		xfer(1'b1, 12'h000, 32'h0000_00A1);
		xfer(1'b1, 12'h000, 32'h0000_00A0);
		pins({16'h0000, 5'b00000});
		rdchk(12'h004, 32'h0000_005A, "high");
		compareHigh <= 1'b1;
		xfer(1'b1, 12'h000, 32'h0000_00A0);
		conv(8'hA1, 8'hFF, 8'hC0, 10, 20);
		compareHigh <= 1'b0;
		conv(8'hB3, 8'h00, 8'h00, 200, 260);
		// Routed differential conversion: settings first, settle, then the same settings with busy.
		xfer(1'b1, 12'h000, 32'h0000_00CC);
		compareHigh <= 1'b1;
		repeat (4) @(posedge sys_clk);
		conv(8'hCD, 8'hFF, 8'hC0, 10, 20);
		print_verdict();
	end
endmodule
